// File: core/aqs_consts.svh
// Constants for the acquisition trigger sequencer: clock rate, rate limits,
// memory size and channel layout.
// Assumes inclusion by core files only; definitions, no logic.
// Operation
// - In continuous mode each converted sample set is pushed to the host unasked, at no more than 30 kHz; external-clock runs have no rate limit.
// - In N-sample mode sample sets go to local memory and leave only on a host transfer command, or on the trigger in pre-trigger capture, up to 200 kHz.
// - Local memory is sized for thirty million samples before a transfer is needed.
// - In software-start mode nothing is sampled until the host start command, after configuration.
// - In event-trigger mode the block waits after configuration for the trigger and then takes N sample sets.
// - In external-clock mode every falling edge of the external clock starts exactly one conversion; edges with a conversion in flight or no room are dropped.
// - The trigger input acts on its falling edge and triggered captures may run at up to 200 kHz.
// - Pre-trigger capture samples into memory before the trigger and sends the N collected sets on the trigger.
// - Post-trigger capture takes no sample before the trigger edge and then takes N sets.
// - Every sampling event yields one 16-bit result for each of eight channels sampled together.
`ifndef AQS_CONSTS_SVH
`define AQS_CONSTS_SVH
`define ACQ_CLK_HZ 125000000
`define ACQ_CONT_MAX_HZ 30000
`define ACQ_NSAMP_MAX_HZ 200000
`define ACQ_MEM_SAMPLES 30000000
`define ACQ_CHANNELS 8
`define ACQ_RES_BITS 16
`define ACQ_PERIOD_BITS 27
`define ACQ_CONT_MIN_CYC ((`ACQ_CLK_HZ + `ACQ_CONT_MAX_HZ - 1) / `ACQ_CONT_MAX_HZ)
`define ACQ_NSAMP_MIN_CYC ((`ACQ_CLK_HZ + `ACQ_NSAMP_MAX_HZ - 1) / `ACQ_NSAMP_MAX_HZ)
`define ACQ_SYNC_TRIG 0
`define ACQ_SYNC_CLK 1
`define ACQ_BUF_DEPTH 2
`endif

// File: core/aqs_pkg.sv
// Types shared by the acquisition trigger sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package aqs_pkg;
   // How a run is started and paced.
   typedef enum logic [1:0] {aqs_mode_soft, aqs_mode_extclk, aqs_mode_trig} aqs_mode_t;
   // Sequencer states.
   typedef enum logic [2:0] {aqs_st_idle, aqs_st_armed, aqs_st_pre, aqs_st_run, aqs_st_hold, aqs_st_xfer} aqs_state_t;
endpackage
`default_nettype wire

// File: core/aqs_sequencer.sv
// Acquisition sequencer: start selection, pacing, converter requests,
// local sample memory addressing and the host-facing sample stream.
// Assumes a converter that answers each conv_start with one adc_done and an
// external memory whose write is seen by any later read.
`timescale 1ns/1ps
`default_nettype none
`include "aqs_consts.svh"
module aqs_sequencer #(
   parameter int MEM_SETS = `ACQ_MEM_SAMPLES / `ACQ_CHANNELS,
   parameter int CONT_MIN_CYC = `ACQ_CONT_MIN_CYC,
   parameter int AW = $clog2(MEM_SETS),
   parameter int PW = `ACQ_PERIOD_BITS,
   parameter int DW = `ACQ_CHANNELS * `ACQ_RES_BITS
) (
   input wire logic clk,
   input wire logic reset,
   input wire aqs_pkg::aqs_mode_t cfg_mode,
   input wire logic cfg_nsamp,
   input wire logic cfg_pretrig,
   input wire logic [AW:0] cfg_count,
   input wire logic [PW-1:0] cfg_period,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic xfer_cmd,
   input wire logic ext_trig,
   input wire logic ext_clk,
   output logic conv_start,
   input wire logic adc_done,
   input wire logic [DW-1:0] adc_data,
   output logic mem_wr_en,
   output logic [AW-1:0] mem_wr_addr,
   output logic [DW-1:0] mem_wr_data,
   output logic mem_rd_en,
   output logic [AW-1:0] mem_rd_addr,
   input wire logic mem_rd_valid,
   input wire logic [DW-1:0] mem_rd_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [DW-1:0] out_data,
   output logic busy,
   output logic data_held,
   output logic overrun
);
   import aqs_pkg::*;
   localparam int CW = AW + 1;
   localparam logic [PW-1:0] CONT_MIN = PW'(CONT_MIN_CYC);
   localparam logic [PW-1:0] NSAMP_MIN = PW'(`ACQ_NSAMP_MIN_CYC);
   localparam logic [CW-1:0] N_MAX = CW'(MEM_SETS);

   aqs_state_t state_ff, nxt_state;
   aqs_mode_t mode_ff;
   logic nsamp_ff, pre_ff, trig_pend_ff, conv_busy_ff, rd_out_ff, conv_start_ff, overrun_ff;
   logic [CW-1:0] n_ff, wr_cnt_ff, rd_left_ff;
   logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, mem_wr_addr_ff, mem_rd_addr_ff;
   logic [DW-1:0] mem_wr_data_ff;
   logic mem_wr_en_ff, mem_rd_en_ff;
   logic [PW-1:0] per_ff, per_cnt_ff;
   logic [1:0] meta_ff, sync_ff, prev_ff;
   logic trig_fall, clk_fall, active, sample_evt, room, issue, rd_issue;
   logic buf_in_valid, buf_in_ready;
   logic [DW-1:0] buf_in_data;
   logic [DW-1:0] buf_ff [`ACQ_BUF_DEPTH];
   logic [1:0] buf_cnt_ff;
   logic buf_head_ff;

   // Two flops per pin, then a third for the edge; only the second and third flops feed logic.
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= {ext_clk, ext_trig};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end
   assign trig_fall = prev_ff[`ACQ_SYNC_TRIG] & ~sync_ff[`ACQ_SYNC_TRIG];
   assign clk_fall = prev_ff[`ACQ_SYNC_CLK] & ~sync_ff[`ACQ_SYNC_CLK];

   // Sequencer next state.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         aqs_st_idle: begin
            if (start_cmd) begin
               if (cfg_mode == aqs_mode_trig) begin
                  nxt_state = cfg_pretrig ? aqs_st_pre : aqs_st_armed;
               end else begin
                  nxt_state = aqs_st_run;
               end
            end
         end
         aqs_st_armed: begin
            if (stop_cmd) nxt_state = aqs_st_idle;
            else if (trig_fall) nxt_state = aqs_st_run;
         end
         aqs_st_pre: begin
            if (stop_cmd) nxt_state = aqs_st_idle;
            else if (trig_pend_ff && !conv_busy_ff) nxt_state = aqs_st_xfer;
         end
         aqs_st_run: begin
            if (stop_cmd) nxt_state = aqs_st_idle;
            else if (nsamp_ff && adc_done && wr_cnt_ff == n_ff - CW'(1)) nxt_state = aqs_st_hold;
         end
         aqs_st_hold: begin
            if (stop_cmd) nxt_state = aqs_st_idle;
            else if (xfer_cmd) nxt_state = aqs_st_xfer;
         end
         aqs_st_xfer: begin
            if (rd_left_ff == '0 && !rd_out_ff) nxt_state = aqs_st_idle;
         end
      endcase
   end

   // State register and run configuration, taken only at the start command.
   // External clock runs are always streamed and trigger runs always buffered.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= aqs_st_idle;
         mode_ff <= aqs_mode_soft;
         nsamp_ff <= '0;
         pre_ff <= '0;
         n_ff <= '0;
         per_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == aqs_st_idle && start_cmd) begin
            mode_ff <= cfg_mode;
            nsamp_ff <= (cfg_mode == aqs_mode_trig) | (cfg_nsamp & (cfg_mode != aqs_mode_extclk));
            pre_ff <= cfg_pretrig;
            n_ff <= (cfg_count > N_MAX) ? N_MAX : ((cfg_count == '0) ? CW'(1) : cfg_count);
            if (cfg_mode != aqs_mode_trig && !cfg_nsamp) begin
               per_ff <= (cfg_period < CONT_MIN) ? CONT_MIN : cfg_period;
            end else begin
               per_ff <= (cfg_period < NSAMP_MIN) ? NSAMP_MIN : cfg_period;
            end
         end
      end
   end

   // Pacing counter; the first sampling event comes the cycle the run opens.
   assign active = (state_ff == aqs_st_run) || (state_ff == aqs_st_pre);
   always_ff @(posedge clk) begin
      if (reset || !active) begin
         per_cnt_ff <= '0;
      end else if (per_cnt_ff == '0) begin
         per_cnt_ff <= per_ff - PW'(1);
      end else begin
         per_cnt_ff <= per_cnt_ff - PW'(1);
      end
   end

   // Only one conversion is in flight, which keeps the buffer and memory
   // accounting simple; an event that finds no room, other than after a pre-trigger edge, is counted as overrun.
   assign sample_evt = active && ((mode_ff == aqs_mode_extclk) ? clk_fall : (per_cnt_ff == '0));
   assign room = nsamp_ff ? ((state_ff == aqs_st_pre && !trig_pend_ff) || wr_cnt_ff < n_ff) : buf_in_ready;
   assign issue = sample_evt && !conv_busy_ff && room && !stop_cmd;
   always_ff @(posedge clk) begin
      if (reset) begin
         conv_start_ff <= '0;
         conv_busy_ff <= '0;
         overrun_ff <= '0;
      end else begin
         conv_start_ff <= issue;
         conv_busy_ff <= issue | (conv_busy_ff & ~adc_done);
         if (state_ff == aqs_st_idle && start_cmd) overrun_ff <= '0;
         else if (sample_evt && !issue && !(state_ff == aqs_st_pre && trig_pend_ff)) overrun_ff <= 1'b1;
      end
   end

   // Pre-trigger edge is held until the conversion in flight has landed.
   always_ff @(posedge clk) begin
      if (reset || state_ff != aqs_st_pre) trig_pend_ff <= '0;
      else if (trig_fall) trig_pend_ff <= 1'b1;
   end

   // Memory write side; the pre-trigger window wraps over the last N sets.
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_ff <= '0;
         wr_cnt_ff <= '0;
         mem_wr_en_ff <= '0;
         mem_wr_addr_ff <= '0;
         mem_wr_data_ff <= '0;
      end else begin
         mem_wr_en_ff <= adc_done && nsamp_ff && !(state_ff == aqs_st_idle && start_cmd);
         if (state_ff == aqs_st_idle && start_cmd) begin
            wr_ptr_ff <= '0;
            wr_cnt_ff <= '0;
         end else if (adc_done && nsamp_ff) begin
            mem_wr_addr_ff <= wr_ptr_ff;
            mem_wr_data_ff <= adc_data;
            wr_ptr_ff <= (CW'(wr_ptr_ff) == n_ff - CW'(1)) ? '0 : wr_ptr_ff + AW'(1);
            wr_cnt_ff <= (wr_cnt_ff == n_ff) ? n_ff : wr_cnt_ff + CW'(1);
         end
      end
   end

   // Memory read side: one read outstanding, issued only with buffer room.
   assign rd_issue = (state_ff == aqs_st_xfer) && rd_left_ff != '0 && !rd_out_ff && buf_in_ready;
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_ptr_ff <= '0;
         rd_left_ff <= '0;
         rd_out_ff <= '0;
         mem_rd_en_ff <= '0;
         mem_rd_addr_ff <= '0;
      end else begin
         mem_rd_en_ff <= rd_issue;
         rd_out_ff <= rd_issue | (rd_out_ff & ~mem_rd_valid);
         if (state_ff == aqs_st_pre && nxt_state == aqs_st_xfer) begin
            rd_ptr_ff <= (wr_cnt_ff == n_ff) ? wr_ptr_ff : '0;
            rd_left_ff <= wr_cnt_ff;
         end else if (state_ff == aqs_st_hold && nxt_state == aqs_st_xfer) begin
            rd_ptr_ff <= '0;
            rd_left_ff <= n_ff;
         end else if (rd_issue) begin
            mem_rd_addr_ff <= rd_ptr_ff;
            rd_ptr_ff <= (CW'(rd_ptr_ff) == n_ff - CW'(1)) ? '0 : rd_ptr_ff + AW'(1);
            rd_left_ff <= rd_left_ff - CW'(1);
         end
      end
   end

   // Two-entry buffer toward the host; streamed sets go straight in.
   assign buf_in_valid = (adc_done & ~nsamp_ff) | mem_rd_valid;
   assign buf_in_data = mem_rd_valid ? mem_rd_data : adc_data;
   assign buf_in_ready = buf_cnt_ff != 2'(`ACQ_BUF_DEPTH);
   always_ff @(posedge clk) begin
      if (reset) begin
         buf_cnt_ff <= '0;
         buf_head_ff <= '0;
      end else begin
         buf_cnt_ff <= buf_cnt_ff + 2'(buf_in_valid & buf_in_ready) - 2'(out_valid & out_ready);
         if (out_valid && out_ready) buf_head_ff <= ~buf_head_ff;
      end
   end
   // Data slots need no reset; out_valid masks them.
   always_ff @(posedge clk) begin
      if (buf_in_valid && buf_in_ready) buf_ff[buf_head_ff ^ (buf_cnt_ff != '0)] <= buf_in_data;
   end

   assign out_valid = buf_cnt_ff != '0;
   assign out_data = buf_ff[buf_head_ff];
   assign conv_start = conv_start_ff;
   assign mem_wr_en = mem_wr_en_ff;
   assign mem_wr_addr = mem_wr_addr_ff;
   assign mem_wr_data = mem_wr_data_ff;
   assign mem_rd_en = mem_rd_en_ff;
   assign mem_rd_addr = mem_rd_addr_ff;
   assign busy = state_ff != aqs_st_idle;
   assign data_held = state_ff == aqs_st_hold;
   assign overrun = overrun_ff;

   // Checks on the sequencer's own signals.
   sequence s_pre_accept;
      state_ff == aqs_st_pre && trig_pend_ff && !conv_busy_ff && !stop_cmd;
   endsequence
   a_cont_streams: assert property (@(posedge clk) disable iff (reset)
      adc_done && !nsamp_ff |=> out_valid) else $error("streamed set not offered to host");
   a_nsamp_holds: assert property (@(posedge clk) disable iff (reset)
      state_ff == aqs_st_hold && !xfer_cmd && !stop_cmd |=> state_ff == aqs_st_hold && !mem_rd_en)
      else $error("held data left without transfer command");
   a_nsamp_source: assert property (@(posedge clk) disable iff (reset)
      buf_in_valid && nsamp_ff |-> state_ff == aqs_st_xfer) else $error("buffered data sent outside transfer");
   a_mem_range: assert property (@(posedge clk) disable iff (reset)
      mem_wr_en |-> CW'(mem_wr_addr) < n_ff && n_ff <= N_MAX) else $error("memory write out of range");
   a_idle_waits: assert property (@(posedge clk) disable iff (reset)
      state_ff == aqs_st_idle && !start_cmd |=> state_ff == aqs_st_idle) else $error("run began without start");
   a_trig_starts: assert property (@(posedge clk) disable iff (reset)
      state_ff == aqs_st_armed && trig_fall && !stop_cmd |=> state_ff == aqs_st_run ##[0:2] conv_start)
      else $error("trigger did not start capture");
   a_extclk_edge: assert property (@(posedge clk) disable iff (reset)
      conv_start && mode_ff == aqs_mode_extclk && $past(active) |-> $past(clk_fall))
      else $error("conversion without external clock edge");
   a_extclk_one: assert property (@(posedge clk) disable iff (reset)
      mode_ff == aqs_mode_extclk && state_ff == aqs_st_run && clk_fall && !conv_busy_ff && buf_in_ready
      && !stop_cmd |=> conv_start) else $error("external clock edge dropped");
   a_trig_fall: assert property (@(posedge clk) disable iff (reset)
      trig_fall |-> $past(ext_trig, 3) && !$past(ext_trig, 2)) else $error("trigger edge misdetected");
   a_pre_deliver: assert property (@(posedge clk) disable iff (reset)
      s_pre_accept |=> state_ff == aqs_st_xfer) else $error("pre-trigger data not delivered");
   a_post_quiet: assert property (@(posedge clk) disable iff (reset)
      state_ff == aqs_st_armed && $past(state_ff) == aqs_st_armed |-> !conv_start)
      else $error("sample taken before trigger");
   a_set_width: assert property (@(posedge clk) disable iff (reset)
      mem_wr_en |-> $past(adc_done) && mem_wr_data == $past(adc_data)) else $error("sample set mangled");
endmodule
`default_nettype wire

// File: verif/aqs_far_model.sv
// Far-side model: converter answering each request and the local sample memory.
// Assumes the sequencer's converter and memory ports; the host sink sits in the bench.
`timescale 1ns/1ps
`default_nettype none
module aqs_far_model #(
   parameter int AW = 4,
   parameter int DW = 128
) (
   input wire logic clk,
   input wire logic conv_start,
   output logic adc_done,
   output logic [DW-1:0] adc_data,
   input wire logic mem_wr_en,
   input wire logic [AW-1:0] mem_wr_addr,
   input wire logic [DW-1:0] mem_wr_data,
   input wire logic mem_rd_en,
   input wire logic [AW-1:0] mem_rd_addr,
   output logic mem_rd_valid,
   output logic [DW-1:0] mem_rd_data,
   output int conv_count
);
   logic [DW-1:0] mem [2**AW];
   logic [3:0] lat_ff = 4'h0;
   logic [1:0] rd_ff = 2'h0;
   logic [AW-1:0] rd_addr_ff;
   logic [DW-1:0] set_w;
   int cnt = 0;
   // Outside their valid cycle the data lines carry the inverse, so a late capture shows up.
   assign conv_count = cnt;
   assign adc_done = lat_ff[3];
   assign adc_data = adc_done ? set_w : ~set_w;
   assign mem_rd_valid = rd_ff[1];
   assign mem_rd_data = mem_rd_valid ? mem[rd_addr_ff] : ~mem[rd_addr_ff];
   // Each set carries its conversion number and channel index, so loss or repeat is visible.
   always_comb begin
      for (int c = 0; c < 8; c++) set_w[c*16 +: 16] = 16'(cnt * 8 + c);
   end
   // Fixed four-cycle conversion and two-cycle memory read.
   always @(posedge clk) begin
      lat_ff <= {lat_ff[2:0], conv_start};
      rd_ff <= {rd_ff[0], mem_rd_en};
      if (mem_rd_en) rd_addr_ff <= mem_rd_addr;
      if (mem_wr_en) mem[mem_wr_addr] <= mem_wr_data;
      if (adc_done) cnt <= cnt + 1;
   end
endmodule
`default_nettype wire

// File: verif/acquisition_trigger_sequencer_tb.sv
// Bench for the acquisition sequencer: a table of runs, then a mid-run reset.
// Assumes the far-side model for converter and memory; the bench acts as host and sink.
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_sequencer_tb;
   import aqs_pkg::*;
   localparam int AW = 4;
   localparam int DW = 128;
   typedef struct {aqs_mode_t m; logic ns; logic pre; int cnt; int per;
      int edges; int words; int gap; int st;} aqs_row_t;
   logic clk = 0, reset = 1, cfg_nsamp = 0, cfg_pretrig = 0, start_cmd = 0, stop_cmd = 0, xfer_cmd = 0;
   logic ext_trig = 1, ext_clk = 1, out_ready = 1;
   aqs_mode_t cfg_mode = aqs_mode_soft;
   logic [AW:0] cfg_count = 5'h01;
   logic [26:0] cfg_period = 27'h0000010;
   logic conv_start, adc_done, mem_wr_en, mem_rd_en, mem_rd_valid, out_valid, busy, data_held, overrun;
   logic [DW-1:0] adc_data, mem_wr_data, mem_rd_data, out_data;
   logic [AW-1:0] mem_wr_addr, mem_rd_addr;
   logic [DW-1:0] got [$];
   int failures = 0, total_checks = 0, cyc = 0, last_c = 0, min_gap, c0, base, conv_count;
   // Ordinary runs: mode, N-sample, pre-trigger, count, period, pin edges, words, interval, stall.
   aqs_row_t rows [9] = '{
      '{aqs_mode_soft, 0, 0, 1, 3, 0, 5, 8, 0},
      '{aqs_mode_soft, 1, 0, 3, 100, 0, 3, 625, 0},
      '{aqs_mode_extclk, 0, 0, 1, 700, 4, 4, 0, 0},
      '{aqs_mode_trig, 1, 0, 2, 625, 0, 2, 625, 0},
      '{aqs_mode_trig, 1, 1, 2, 625, 0, 2, 625, 0},
      '{aqs_mode_soft, 1, 0, 0, 625, 0, 1, 0, 0},
      '{aqs_mode_soft, 1, 0, 20, 625, 0, 16, 625, 0},
      '{aqs_mode_soft, 0, 0, 1, 8, 0, 5, 0, 300},
      '{aqs_mode_soft, 1, 0, 3, 625, 0, 3, 625, 100}
   };
   aqs_sequencer #(.MEM_SETS(16), .CONT_MIN_CYC(8)) i_dut (.clk, .reset, .cfg_mode, .cfg_nsamp, .cfg_pretrig,
      .cfg_count, .cfg_period, .start_cmd, .stop_cmd, .xfer_cmd, .ext_trig, .ext_clk, .conv_start, .adc_done,
      .adc_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .mem_rd_en, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
      .out_valid, .out_ready, .out_data, .busy, .data_held, .overrun);
   aqs_far_model #(.AW(AW), .DW(DW)) i_far (.clk, .conv_start, .adc_done, .adc_data, .mem_wr_en, .mem_wr_addr,
      .mem_wr_data, .mem_rd_en, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .conv_count);
   // Expected set for a conversion number, worked out independently of the design.
   function automatic logic [DW-1:0] pat(input int k);
      for (int c = 0; c < 8; c++) pat[c*16 +: 16] = 16'(k * 8 + c);
   endfunction
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bad(input string s);
      failures++;
      $display("ERROR %0t %s", $time, s);
   endtask
   task automatic chk_word(input logic [DW-1:0] a, input logic [DW-1:0] e);
      total_checks++;
      if (a !== e) bad("stream word mismatch");
   endtask
   task automatic chk_bit(input logic a, input logic e, input string s);
      total_checks++;
      if (a !== e) bad(s);
   endtask
   task automatic chk_int(input int a, input int e, input string s);
      total_checks++;
      if (a != e) bad(s);
   endtask
   // Bounded wait: 0 data held, 1 idle, 2 enough words received.
   task automatic wait_on(input int sel, input int n);
      int k;
      for (k = 0; k < 20000; k++) begin
         if ((sel == 0 && data_held === 1'b1) || (sel == 1 && busy === 1'b0) || (sel == 2 && got.size() >= n)) break;
         @(posedge clk);
      end
      if (k == 20000) begin
         bad("wait timed out");
         test_done();
      end
   endtask
   // One-cycle command pulse: 0 start, 1 stop, 2 transfer.
   task automatic cmd(input int w);
      @(posedge clk);
      start_cmd <= (w == 0);
      stop_cmd <= (w == 1);
      xfer_cmd <= (w == 2);
      @(posedge clk);
      {start_cmd, stop_cmd, xfer_cmd} <= 3'h0;
   endtask
   // Low and high phases well above the two-cycle minimum the synchroniser needs.
   task automatic pin(input logic trig);
      @(posedge clk);
      if (trig) ext_trig <= 1'b0;
      else ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
      ext_trig <= 1'b1;
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   // Host sink and sampling interval monitor.
   always @(posedge clk) begin
      cyc++;
      if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
      if (conv_start === 1'b1) begin
         if (last_c > 0 && cyc - last_c < min_gap) min_gap = cyc - last_c; // A row's first request has no interval.
         last_c = cyc;
      end
   end
   initial begin
      aqs_row_t r;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         r = rows[i];
         got.delete();
         min_gap = 1 << 30;
         last_c = 0;
         c0 = conv_count;
         cfg_mode <= r.m;
         cfg_nsamp <= r.ns;
         cfg_pretrig <= r.pre;
         cfg_count <= 5'(r.cnt);
         cfg_period <= 27'(r.per);
         cmd(0);
         @(posedge clk);
         chk_bit(busy, 1'b1, "not busy after start");
         chk_bit(overrun, 1'b0, "overrun kept over start");
         repeat (r.edges) pin(1'b0);
         if (r.m == aqs_mode_trig) begin
            repeat (r.pre ? 2000 : 300) @(posedge clk);
            chk_int(conv_count - c0 == 0, !r.pre, "sampling before trigger");
            pin(1'b1);
         end
         if (r.ns && !r.pre) begin
            wait_on(0, 0);
            chk_int(got.size(), 0, "data sent before transfer command");
            cmd(2);
         end
         if (r.st > 0) begin
            out_ready <= 1'b0;
            repeat (r.st) @(posedge clk);
            chk_bit(overrun, !r.ns, "overrun flag");
            chk_bit(out_valid, 1'b1, "stalled word withdrawn");
            out_ready <= 1'b1;
         end
         wait_on(2, r.words);
         repeat (8) @(posedge clk);
         if (busy === 1'b1) cmd(1);
         wait_on(1, 0);
         // A conversion cut off by the stop still lands; let it drain before the next row counts.
         repeat (8) @(posedge clk);
         base = r.pre ? conv_count - r.words : c0;
         for (int k = 0; k < r.words; k++) chk_word(got[k], pat(base + k));
         if (r.ns || r.edges > 0) chk_int(got.size(), r.words, "word count");
         if (r.gap > 0) chk_int(min_gap, r.gap, "sampling interval");
         $display("row %0d done", i);
      end
      cfg_mode <= aqs_mode_soft;
      cfg_nsamp <= 1'b0;
      cmd(0);
      repeat (40) @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      chk_bit(busy, 1'b0, "busy over reset");
      chk_bit(out_valid, 1'b0, "stream valid over reset");
      reset <= 1'b0;
      cmd(0);
      @(posedge clk);
      chk_bit(busy, 1'b1, "no start after reset");
      chk_bit(overrun, 1'b0, "overrun after reset");
      $display("reset test done");
      test_done();
   end
endmodule
`default_nettype wire
